// file: design/asim_alu.sv
// Combinational result unit: OR, shifts, move and indirect load value.
// Operand is the byte fetched from memory; accum is the current accumulator.
`timescale 1ns/10ps
`default_nettype none
module asim_alu
  import asim_pkg::*;
(
  input wire asim_op_t op, // Operation
  input wire logic [DATA_W-1:0] accum, // Accumulator value
  input wire logic [DATA_W-1:0] operand, // Fetched byte
  output asim_result_t res // Result, carry and zero
);

  always_comb begin
    res.carry = 1'b0;
    res.carry_upd = 1'b0;
    unique case (op)
      OP_OR_ACCUM_INTO_FILE: begin
        res.value = accum | operand;
      end
      OP_LOGICAL_LEFT_SHIFT: begin
        res.value = {operand[6:0], 1'b0};
        res.carry = operand[7];
        res.carry_upd = 1'b1;
      end
      OP_LOGICAL_RIGHT_SHIFT: begin
        res.value = {1'b0, operand[7:1]};
        res.carry = operand[0];
        res.carry_upd = 1'b1;
      end
      default: begin
        // Move and indirect load both pass the byte through
        res.value = operand;
      end
    endcase
    res.zero = (res.value == 8'h00);
  end

endmodule : asim_alu
`default_nettype wire

// file: design/asim_core.sv
// Execution datapath for OR-into-file, logical shifts, move-file and indirect read.
// Assumes a synchronous memory answering mem_rdata one cycle after mem_rd_ff.
// Notes on behaviour
// - OR accumulator with file register 0-127
// - Target bit 0 accumulator, 1 file register
// - Left shift: bit7 to carry, zero in
// - Right shift: bit0 to carry, zero in
// - Move file to target, zero flag updated
// - Indirect read: pointer pick, four update modes
// - Relative form: pointer plus signed -32..31
// - Pointer ends plus, minus one, or unchanged
// - Indirect read loads accumulator, updates zero
// - Window addresses redirect through their pointer
// - Pointers wrap modulo sixteen bits
`timescale 1ns/10ps
`default_nettype none
module asim_core
  import asim_pkg::*;
(
  input wire logic mclk, // Instruction clock
  input wire logic rst, // Async reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic instr_valid, // Instruction offered
  input wire asim_instr_t instr, // Decoded instruction
  input wire logic acc_ld_en, // Load accumulator from outside
  input wire logic [DATA_W-1:0] acc_ld_data, // Accumulator load value
  input wire logic ptr_ld_en, // Load a pointer from outside
  input wire logic ptr_ld_sel, // Pointer chosen for load
  input wire logic [PTR_W-1:0] ptr_ld_data, // Pointer load value
  input wire logic [DATA_W-1:0] mem_rdata, // Memory read data
  output logic busy_ff, // Instruction in flight
  output logic done_ff, // Instruction retired, one cycle
  output logic [PTR_W-1:0] mem_addr_ff, // Memory address
  output logic mem_rd_ff, // Memory read strobe
  output logic mem_we_ff, // Memory write strobe
  output logic [DATA_W-1:0] mem_wdata_ff, // Memory write data
  output logic [DATA_W-1:0] accum_ff, // Accumulator
  output logic zero_ff, // Null result flag
  output logic carry_ff, // Shift-out bit
  output logic [PTR_W-1:0] ptr0_ff, // Pointer 0
  output logic [PTR_W-1:0] ptr1_ff // Pointer 1
);

  typedef enum logic [1:0] {S_IDLE, S_REQ, S_DATA} asim_state_t;

  asim_state_t state_ff, nxt_state;
  asim_instr_t instr_ff, nxt_instr;
  asim_result_t res;
  logic nxt_busy, nxt_done, nxt_rd, nxt_we, nxt_zero, nxt_carry;
  logic [PTR_W-1:0] nxt_addr, nxt_ptr0, nxt_ptr1;
  logic [DATA_W-1:0] nxt_wdata, nxt_accum;

  function automatic logic [PTR_W-1:0] pick_ptr(input logic sel, input logic [PTR_W-1:0] p0,
                                                input logic [PTR_W-1:0] p1);
    pick_ptr = sel ? p1 : p0;
  endfunction : pick_ptr

  // Effective address of an indirect read; sums truncate so pointers wrap
  function automatic logic [PTR_W-1:0] eff_addr(input asim_instr_t i, input logic [PTR_W-1:0] p);
    logic [PTR_W-1:0] sx;
    sx = {{(PTR_W-OFS_W){i.offset[OFS_W-1]}}, i.offset};
    if (i.rel) begin
      eff_addr = PTR_W'(p + sx);
    end else begin
      unique case (i.mode)
        MODE_PRE_INC: eff_addr = PTR_W'(p + PTR_STEP);
        MODE_PRE_DEC: eff_addr = PTR_W'(p - PTR_STEP);
        default: eff_addr = p;
      endcase
    end
  endfunction : eff_addr

  function automatic logic [PTR_W-1:0] final_ptr(input asim_instr_t i, input logic [PTR_W-1:0] p);
    if (i.rel) begin
      final_ptr = p;
    end else if (i.mode == MODE_PRE_INC || i.mode == MODE_POST_INC) begin
      final_ptr = PTR_W'(p + PTR_STEP);
    end else begin
      final_ptr = PTR_W'(p - PTR_STEP);
    end
  endfunction : final_ptr

  asim_alu u_alu (
    .op(instr_ff.op),
    .accum(accum_ff),
    .operand(mem_rdata),
    .res(res)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_instr = instr_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_rd = 1'b0;
    nxt_we = 1'b0;
    nxt_addr = mem_addr_ff;
    nxt_wdata = mem_wdata_ff;
    nxt_accum = acc_ld_en ? acc_ld_data : accum_ff;
    nxt_zero = zero_ff;
    nxt_carry = carry_ff;
    nxt_ptr0 = ptr0_ff;
    nxt_ptr1 = ptr1_ff;
    if (ptr_ld_en && !ptr_ld_sel) begin
      nxt_ptr0 = ptr_ld_data;
    end
    if (ptr_ld_en && ptr_ld_sel) begin
      nxt_ptr1 = ptr_ld_data;
    end
    unique case (state_ff)
      S_IDLE: begin
        if (instr_valid) begin
          nxt_instr = instr;
          nxt_state = S_REQ;
          nxt_busy = 1'b1;
          nxt_rd = 1'b1;
          if (instr.op == OP_INDIRECT_READ_TO_ACCUM) begin
            nxt_addr = eff_addr(instr, pick_ptr(instr.psel, ptr0_ff, ptr1_ff));
          end else if (instr.faddr == WINDOW0_ADDR) begin
            nxt_addr = ptr0_ff;
          end else if (instr.faddr == WINDOW1_ADDR) begin
            nxt_addr = ptr1_ff;
          end else begin
            nxt_addr = {{(PTR_W-FADDR_W){1'b0}}, instr.faddr};
          end
        end
      end
      S_REQ: begin
        nxt_state = S_DATA;
      end
      S_DATA: begin
        nxt_state = S_IDLE;
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        nxt_zero = res.zero;
        if (res.carry_upd) begin
          nxt_carry = res.carry;
        end
        // Instruction result wins over an outside load in the same cycle
        if (instr_ff.op == OP_INDIRECT_READ_TO_ACCUM) begin
          nxt_accum = res.value;
          if (!instr_ff.psel) begin
            nxt_ptr0 = final_ptr(instr_ff, ptr0_ff);
          end else begin
            nxt_ptr1 = final_ptr(instr_ff, ptr1_ff);
          end
        end else if (instr_ff.dest == DEST_FILE) begin
          nxt_we = 1'b1;
          nxt_wdata = res.value;
        end else begin
          nxt_accum = res.value;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      instr_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      mem_rd_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= PTR_RST;
      mem_wdata_ff <= ACCUM_RST;
      accum_ff <= ACCUM_RST;
      zero_ff <= 1'b0;
      carry_ff <= 1'b0;
      ptr0_ff <= PTR_RST;
      ptr1_ff <= PTR_RST;
    end else if (ce) begin
      state_ff <= nxt_state;
      instr_ff <= nxt_instr;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      mem_rd_ff <= nxt_rd;
      mem_we_ff <= nxt_we;
      mem_addr_ff <= nxt_addr;
      mem_wdata_ff <= nxt_wdata;
      accum_ff <= nxt_accum;
      zero_ff <= nxt_zero;
      carry_ff <= nxt_carry;
      ptr0_ff <= nxt_ptr0;
      ptr1_ff <= nxt_ptr1;
    end
  end

  // Checking helpers
  logic [DATA_W-1:0] seen_val;
  logic [PTR_W-1:0] sel_ptr;
  logic is_ind;
  assign seen_val = mem_we_ff ? mem_wdata_ff : accum_ff;
  assign sel_ptr = pick_ptr(instr.psel, ptr0_ff, ptr1_ff);
  assign is_ind = (instr_ff.op == OP_INDIRECT_READ_TO_ACCUM);

  sequence s_issue;
    state_ff == S_IDLE && ce && instr_valid && !rst;
  endsequence
  sequence s_data;
    state_ff == S_DATA && ce;
  endsequence

  property p_or;
    @(posedge mclk) disable iff (rst)
    s_data and (instr_ff.op == OP_OR_ACCUM_INTO_FILE) |=>
      seen_val == ($past(accum_ff) | $past(mem_rdata));
  endproperty
  a_or: assert property (p_or) else $error("OR result wrong");

  property p_dest;
    @(posedge mclk) disable iff (rst)
    s_data and !is_ind |=> (mem_we_ff == $past(instr_ff.dest)) &&
      ($past(instr_ff.dest) ? accum_ff == $past(accum_ff) || $past(acc_ld_en) : 1'b1);
  endproperty
  a_dest: assert property (p_dest) else $error("Target select ignored");

  property p_lsl;
    @(posedge mclk) disable iff (rst)
    s_data and (instr_ff.op == OP_LOGICAL_LEFT_SHIFT) |=>
      carry_ff == $past(mem_rdata[7]) && seen_val == {$past(mem_rdata[6:0]), 1'b0};
  endproperty
  a_lsl: assert property (p_lsl) else $error("Left shift wrong");

  property p_lsr;
    @(posedge mclk) disable iff (rst)
    s_data and (instr_ff.op == OP_LOGICAL_RIGHT_SHIFT) |=>
      carry_ff == $past(mem_rdata[0]) && seen_val == {1'b0, $past(mem_rdata[7:1])};
  endproperty
  a_lsr: assert property (p_lsr) else $error("Right shift wrong");

  property p_move;
    @(posedge mclk) disable iff (rst)
    (s_issue and (instr.op == OP_MOVE_FILE_REGISTER)) ##1 ce ##1 ce |=>
      done_ff && seen_val == $past(mem_rdata);
  endproperty
  a_move: assert property (p_move) else $error("Move not done in time");

  property p_mode;
    @(posedge mclk) disable iff (rst)
    s_issue and (instr.op == OP_INDIRECT_READ_TO_ACCUM) and !instr.rel |=>
      mem_rd_ff && mem_addr_ff == ($past(instr.mode) == MODE_PRE_INC ?
      PTR_W'($past(sel_ptr) + 16'h1) :
      $past(instr.mode) == MODE_PRE_DEC ? PTR_W'($past(sel_ptr) - 16'h1) : $past(sel_ptr));
  endproperty
  a_mode: assert property (p_mode) else $error("Indirect address mode wrong");

  property p_rel;
    @(posedge mclk) disable iff (rst)
    s_issue and (instr.op == OP_INDIRECT_READ_TO_ACCUM) and instr.rel |=>
      mem_addr_ff == PTR_W'($past(sel_ptr) + {{10{$past(instr.offset[5])}}, $past(instr.offset)});
  endproperty
  a_rel: assert property (p_rel) else $error("Relative address wrong");

  property p_final;
    @(posedge mclk) disable iff (rst)
    s_data and is_ind and !ptr_ld_en |=> pick_ptr($past(instr_ff.psel), ptr0_ff, ptr1_ff) ==
      ($past(instr_ff.rel) ? pick_ptr($past(instr_ff.psel), $past(ptr0_ff), $past(ptr1_ff)) :
      $past(instr_ff.mode[0]) ? PTR_W'(pick_ptr($past(instr_ff.psel), $past(ptr0_ff),
      $past(ptr1_ff)) - 16'h1) : PTR_W'(pick_ptr($past(instr_ff.psel), $past(ptr0_ff),
      $past(ptr1_ff)) + 16'h1));
  endproperty
  a_final: assert property (p_final) else $error("Pointer end value wrong");

  property p_load;
    @(posedge mclk) disable iff (rst)
    s_data and is_ind |=> !mem_we_ff && accum_ff == $past(mem_rdata) &&
      zero_ff == (accum_ff == 8'h00);
  endproperty
  a_load: assert property (p_load) else $error("Indirect load wrong");

  property p_window;
    @(posedge mclk) disable iff (rst)
    s_issue and (instr.op != OP_INDIRECT_READ_TO_ACCUM) and (instr.faddr == WINDOW1_ADDR) |=>
      mem_addr_ff == $past(ptr1_ff);
  endproperty
  a_window: assert property (p_window) else $error("Window not redirected");

  property p_wrap;
    @(posedge mclk) disable iff (rst)
    s_data and is_ind and !instr_ff.rel and !instr_ff.psel and !instr_ff.mode[0] and !ptr_ld_en and
      (ptr0_ff == 16'hffff) |=> ptr0_ff == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Pointer did not wrap");

  property p_zero;
    @(posedge mclk) disable iff (rst)
    done_ff |-> zero_ff == (seen_val == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("Zero flag wrong");

endmodule : asim_core
`default_nettype wire

// file: design/asim_pkg.sv
// Shared types and constants for the shift, OR, move and indirect-read datapath.
// Assumes a single 50 MHz instruction clock and an external byte memory.
package asim_pkg;

  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PTR_W = 16;
  localparam int OFS_W = 6;

  localparam logic [FADDR_W-1:0] WINDOW0_ADDR = 7'h00;
  localparam logic [FADDR_W-1:0] WINDOW1_ADDR = 7'h01;

  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_STEP = 16'h0001;

  typedef enum logic [2:0] {
    OP_OR_ACCUM_INTO_FILE,
    OP_LOGICAL_LEFT_SHIFT,
    OP_LOGICAL_RIGHT_SHIFT,
    OP_MOVE_FILE_REGISTER,
    OP_INDIRECT_READ_TO_ACCUM
  } asim_op_t;

  typedef struct packed {
    asim_op_t op;
    logic [FADDR_W-1:0] faddr;
    logic dest;
    logic psel;
    logic rel;
    logic [1:0] mode;
    logic [OFS_W-1:0] offset;
  } asim_instr_t;

  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic carry;
    logic carry_upd;
    logic zero;
  } asim_result_t;

endpackage : asim_pkg

// file: verif/tb_top.sv
// Self-checking bench for the asim_core datapath.
// Bench acts as instruction source and byte memory; inputs move on falling edges.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import asim_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic instr_valid = 1'b0;
  asim_instr_t instr = '0;
  logic acc_ld_en = 1'b0;
  logic [DATA_W-1:0] acc_ld_data = 8'h00;
  logic ptr_ld_en = 1'b0;
  logic ptr_ld_sel = 1'b0;
  logic [PTR_W-1:0] ptr_ld_data = 16'h0000;
  logic [DATA_W-1:0] mem_rdata = 8'h00;
  logic busy_ff, done_ff, mem_rd_ff, mem_we_ff, zero_ff, carry_ff;
  logic [PTR_W-1:0] mem_addr_ff, ptr0_ff, ptr1_ff;
  logic [DATA_W-1:0] mem_wdata_ff, accum_ff;
  int bad_count = 0;
  int check_count = 0;

  always #10 mclk = ~mclk;

  asim_core i_dut (.mclk(mclk), .rst(rst), .ce(ce), .instr_valid(instr_valid), .instr(instr),
    .acc_ld_en(acc_ld_en), .acc_ld_data(acc_ld_data), .ptr_ld_en(ptr_ld_en),
    .ptr_ld_sel(ptr_ld_sel), .ptr_ld_data(ptr_ld_data), .mem_rdata(mem_rdata),
    .busy_ff(busy_ff), .done_ff(done_ff), .mem_addr_ff(mem_addr_ff), .mem_rd_ff(mem_rd_ff),
    .mem_we_ff(mem_we_ff), .mem_wdata_ff(mem_wdata_ff), .accum_ff(accum_ff),
    .zero_ff(zero_ff), .carry_ff(carry_ff), .ptr0_ff(ptr0_ff), .ptr1_ff(ptr1_ff));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  function automatic asim_instr_t fop(input asim_op_t op, input logic [6:0] fa, input logic d);
    return asim_instr_t'{op, fa, d, 1'b0, 1'b0, 2'h0, 6'h00};
  endfunction : fop

  function automatic asim_instr_t fin(input logic ps, input logic rl, input logic [1:0] md,
                                      input logic [5:0] ofs);
    return asim_instr_t'{OP_INDIRECT_READ_TO_ACCUM, 7'h00, DEST_ACCUM, ps, rl, md, ofs};
  endfunction : fin

  task automatic ld_acc(input logic [7:0] v);
    @(negedge mclk);
    acc_ld_en = 1'b1;
    acc_ld_data = v;
    @(negedge mclk);
    acc_ld_en = 1'b0;
  endtask : ld_acc

  task automatic ld_ptr(input logic sel, input logic [15:0] v);
    @(negedge mclk);
    ptr_ld_en = 1'b1;
    ptr_ld_sel = sel;
    ptr_ld_data = v;
    @(negedge mclk);
    ptr_ld_en = 1'b0;
  endtask : ld_ptr

  // One instruction: offer, serve the read, optionally stall with ce, check retire
  task automatic exec(input asim_instr_t ins, input logic [7:0] rd, input logic [15:0] ea,
                      input logic [7:0] res, input int stall);
    int n;
    logic we_exp;
    we_exp = (ins.op != OP_INDIRECT_READ_TO_ACCUM) && (ins.dest == DEST_FILE);
    @(negedge mclk);
    instr = ins;
    instr_valid = 1'b1;
    @(negedge mclk);
    instr_valid = 1'b0;
    chk("mem_rd", 16'(mem_rd_ff), 16'h0001);
    chk("busy", 16'(busy_ff), 16'h0001);
    chk("mem_addr", mem_addr_ff, ea);
    mem_rdata = rd;
    for (n = 0; n < stall; n++) begin
      ce = 1'b0;
      @(negedge mclk);
    end
    ce = 1'b1;
    n = 0;
    while (done_ff !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    if (done_ff !== 1'b1) begin
      bad_count++;
      end_sim();
    end
    chk("retire_cycles", 16'(n), 16'h0002);
    chk("busy_retire", 16'(busy_ff), 16'h0000);
    chk("mem_we", 16'(mem_we_ff), 16'(we_exp));
    if (we_exp) begin
      chk("mem_wdata", 16'(mem_wdata_ff), 16'(res));
    end
    // Stale read data must not look valid
    mem_rdata = ~rd;
  endtask : exec

  task automatic t_or;
    ld_acc(8'h5a);
    exec(fop(OP_OR_ACCUM_INTO_FILE, 7'h7f, DEST_ACCUM), 8'ha1, 16'h007f, 8'hfb, 0);
    chk("accum", 16'(accum_ff), 16'h00fb);
    chk("zero", 16'(zero_ff), 16'h0000);
    ld_acc(8'h00);
    exec(fop(OP_OR_ACCUM_INTO_FILE, 7'h40, DEST_FILE), 8'h00, 16'h0040, 8'h00, 0);
    chk("zero", 16'(zero_ff), 16'h0001);
    $display("test or done");
  endtask : t_or

  task automatic sh(input asim_op_t op, input logic d, input logic [7:0] rd,
                    input logic [7:0] res, input logic c);
    exec(fop(op, 7'h05, d), rd, 16'h0005, res, 0);
    if (d == DEST_ACCUM) begin
      chk("accum", 16'(accum_ff), 16'(res));
    end
    chk("carry", 16'(carry_ff), 16'(c));
    chk("zero", 16'(zero_ff), 16'(res == 8'h00));
  endtask : sh

  task automatic t_shift;
    sh(OP_LOGICAL_RIGHT_SHIFT, DEST_ACCUM, 8'hfe, 8'h7f, 1'b0);
    sh(OP_LOGICAL_LEFT_SHIFT, DEST_ACCUM, 8'h81, 8'h02, 1'b1);
    sh(OP_LOGICAL_LEFT_SHIFT, DEST_FILE, 8'h80, 8'h00, 1'b1);
    sh(OP_LOGICAL_RIGHT_SHIFT, DEST_FILE, 8'h01, 8'h00, 1'b1);
    $display("test shift done");
  endtask : t_shift

  task automatic t_move;
    ld_acc(8'h3c);
    // Carry is left at one by the shift test; a move must not touch it
    exec(fop(OP_MOVE_FILE_REGISTER, 7'h22, DEST_FILE), 8'h00, 16'h0022, 8'h00, 2);
    chk("zero", 16'(zero_ff), 16'h0001);
    chk("carry", 16'(carry_ff), 16'h0001);
    chk("accum", 16'(accum_ff), 16'h003c);
    exec(fop(OP_MOVE_FILE_REGISTER, 7'h23, DEST_ACCUM), 8'hc5, 16'h0023, 8'hc5, 0);
    chk("accum", 16'(accum_ff), 16'h00c5);
    chk("zero", 16'(zero_ff), 16'h0000);
    $display("test move done");
  endtask : t_move

  task automatic ind(input logic ps, input logic rl, input logic [1:0] md, input logic [5:0] ofs,
                     input logic [7:0] rd, input logic [15:0] ea, input logic [15:0] pa);
    exec(fin(ps, rl, md, ofs), rd, ea, rd, 0);
    chk("accum", 16'(accum_ff), 16'(rd));
    chk("zero", 16'(zero_ff), 16'(rd == 8'h00));
    chk("pointer", ps ? ptr1_ff : ptr0_ff, pa);
  endtask : ind

  task automatic t_indirect;
    ld_ptr(1'b0, 16'hffff);
    ld_ptr(1'b1, 16'h0000);
    ind(1'b0, 1'b0, MODE_PRE_INC, 6'h00, 8'h00, 16'h0000, 16'h0000);
    ind(1'b1, 1'b0, MODE_PRE_DEC, 6'h00, 8'h9c, 16'hffff, 16'hffff);
    ind(1'b0, 1'b0, MODE_POST_INC, 6'h00, 8'h11, 16'h0000, 16'h0001);
    ind(1'b1, 1'b0, MODE_POST_DEC, 6'h00, 8'h22, 16'hffff, 16'hfffe);
    ind(1'b0, 1'b1, MODE_PRE_INC, 6'h20, 8'h00, 16'hffe1, 16'h0001);
    ind(1'b1, 1'b1, MODE_POST_DEC, 6'h1f, 8'h47, 16'h001d, 16'hfffe);
    $display("test indirect done");
  endtask : t_indirect

  task automatic t_window;
    ld_ptr(1'b1, 16'h1234);
    ld_ptr(1'b0, 16'h00a5);
    exec(fop(OP_MOVE_FILE_REGISTER, WINDOW1_ADDR, DEST_ACCUM),
         8'h80, 16'h1234, 8'h80, 0);
    chk("accum", 16'(accum_ff), 16'h0080);
    chk("pointer", ptr1_ff, 16'h1234);
    exec(fop(OP_LOGICAL_LEFT_SHIFT, WINDOW0_ADDR, DEST_FILE),
         8'h40, 16'h00a5, 8'h80, 0);
    chk("pointer", ptr0_ff, 16'h00a5);
    $display("test window done");
  endtask : t_window

  // A second offer while busy must be ignored, not queued
  task automatic t_refuse;
    @(negedge mclk);
    instr = fop(OP_MOVE_FILE_REGISTER, 7'h10, DEST_ACCUM);
    instr_valid = 1'b1;
    @(negedge mclk);
    instr = fop(OP_MOVE_FILE_REGISTER, 7'h11, DEST_ACCUM);
    mem_rdata = 8'h33;
    @(negedge mclk);
    instr_valid = 1'b0;
    chk("busy", 16'(busy_ff), 16'h0001);
    chk("mem_addr", mem_addr_ff, 16'h0010);
    @(negedge mclk);
    chk("done", 16'(done_ff), 16'h0001);
    chk("accum", 16'(accum_ff), 16'h0033);
    @(negedge mclk);
    chk("busy", 16'(busy_ff), 16'h0000);
    chk("done", 16'(done_ff), 16'h0000);
    chk("mem_addr", mem_addr_ff, 16'h0010);
    $display("test refuse done");
  endtask : t_refuse

  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    t_or();
    t_shift();
    t_move();
    t_indirect();
    t_window();
    t_refuse();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
